// ==== core/dtok_params.svh ====
// Purpose: constants of the deferred token tracking unit
// Assumes: included by the dtok_addr_table and dtok_unit design files, not by the package
// Notes:   offsets are byte addresses on the register bus
`ifndef DTOK_PARAMS_SVH
`define DTOK_PARAMS_SVH

`define DTOK_NUM_GR        128
`define DTOK_COLL_HI       8
`define DTOK_COLL_LO       3
`define DTOK_TBL_IDX_W     3
`define DTOK_TBL_ENTRIES   8
`define DTOK_FP_TOKEN      82'h3FFFF000000000000000

`define DTOK_OFF_CTRL      8'h00
`define DTOK_OFF_COLL_LO   8'h04
`define DTOK_OFF_COLL_HI   8'h08
`define DTOK_OFF_STATUS    8'h0C
`define DTOK_OFF_TOKSEL    8'h10
`define DTOK_OFF_TOKVAL    8'h14

`define DTOK_CTRL_RESET    4'hF
`define DTOK_RESP_OKAY     2'h0
`define DTOK_RESP_SLVERR   2'h2

`endif

// ==== core/dtok_pkg.sv ====
// Purpose: types shared by the deferred token tracking unit
// Assumes: operation codes are driven by instruction decode
// Notes:   bus states are one-hot
package dtok_pkg;

  typedef enum logic [3:0] {
    DTOK_OP_NONE      = 4'h0,
    DTOK_OP_SPEC_ALU  = 4'h1,
    DTOK_OP_ALU       = 4'h2,
    DTOK_OP_LOAD      = 4'h3,
    DTOK_OP_CTRL_LOAD = 4'h4,
    DTOK_OP_ADV_LOAD  = 4'h5,
    DTOK_OP_SADV_LOAD = 4'h6,
    DTOK_OP_SPEC_CHK  = 4'h7,
    DTOK_OP_ADV_CHK   = 4'h8,
    DTOK_OP_TOK_TEST  = 4'h9,
    DTOK_OP_FP_CLASS  = 4'hA,
    DTOK_OP_GR_SPILL  = 4'hB,
    DTOK_OP_GR_FILL   = 4'hC,
    DTOK_OP_FP_SPILL  = 4'hD,
    DTOK_OP_FP_FILL   = 4'hE,
    DTOK_OP_STORE     = 4'hF
  } dtok_op_t;

  typedef enum logic [1:0] {
    DTOK_BUS_IDLE = 2'b01,
    DTOK_BUS_RESP = 2'b10
  } dtok_bus_t;

endpackage

// ==== core/dtok_addr_table.sv ====
// Purpose: advanced load address table, direct mapped by register
// Assumes: one allocation, one store and one check per cycle
// Notes:   overlap is judged on the 8-byte granule of each start address, entSize unused,
//          which may drop extra entries and keeps a stale one when an access crosses a granule
`timescale 1ns/1ps
`include "dtok_params.svh"
module dtok_addr_table
  import dtok_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // allocation by an advanced load
  input  wire logic        allocEn,
  input  wire logic [6:0]  allocReg,
  input  wire logic [63:0] allocAddr,
  input  wire logic        allocFp,
  input  wire logic [3:0]  allocSize,
  // removal of the entry of one register
  input  wire logic        killEn,
  input  wire logic [6:0]  killReg,
  // store snoop
  input  wire logic        storeEn,
  input  wire logic [63:0] storeAddr,
  // check lookup
  input  wire logic [6:0]  chkReg,
  input  wire logic        chkFp,
  input  wire logic        chkClr,
  input  wire logic        chkEn,
  output logic             chkHit
);

  logic [`DTOK_TBL_ENTRIES-1:0] entValid;
  logic [`DTOK_TBL_ENTRIES-1:0] entHit;
  logic [6:0]                   entReg  [`DTOK_TBL_ENTRIES];
  logic [63:0]                  entAddr [`DTOK_TBL_ENTRIES];
  logic                         entFp   [`DTOK_TBL_ENTRIES];
  logic [3:0]                   entSize [`DTOK_TBL_ENTRIES];

  genvar gi;
  generate
    for (gi = 0; gi < `DTOK_TBL_ENTRIES; gi++) begin : g_ent
      logic selAlloc;
      logic selKill;
      logic selChk;
      logic storeHit;
      // each register maps to one slot, so a newer load to the same
      // register and an unrelated register sharing its low three bits both simply overwrite it
      assign selAlloc = allocEn &&
        (allocReg[`DTOK_TBL_IDX_W-1:0] == gi[`DTOK_TBL_IDX_W-1:0]);
      assign selKill = killEn &&
        (killReg[`DTOK_TBL_IDX_W-1:0] == gi[`DTOK_TBL_IDX_W-1:0]);
      assign selChk = (chkReg[`DTOK_TBL_IDX_W-1:0] ==
                       gi[`DTOK_TBL_IDX_W-1:0]);
      assign storeHit = storeEn && entValid[gi] &&
        (storeAddr[63:3] == entAddr[gi][63:3]);
      assign entHit[gi] = selChk && entValid[gi] &&
        (entReg[gi] == chkReg) && (entFp[gi] == chkFp);

      // allocation wins over removal in the same cycle
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          entValid[gi] <= 1'b0;
          entReg[gi]   <= 7'h00;
          entAddr[gi]  <= 64'h0000000000000000;
          entFp[gi]    <= 1'b0;
          entSize[gi]  <= 4'h0;
        end else if (selAlloc) begin
          entValid[gi] <= 1'b1;
          entReg[gi]   <= allocReg;
          entAddr[gi]  <= allocAddr;
          entFp[gi]    <= allocFp;
          entSize[gi]  <= allocSize;
        end else if (selKill || storeHit ||
                     (chkEn && chkClr && entHit[gi])) begin
          entValid[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign chkHit = |entHit;

endmodule

// ==== core/dtok_unit.sv ====
// Purpose: deferred exception token tracking for control speculation
// Assumes: decode presents one operation per cycle on opValid
// Notes:   results appear one cycle after the operation is taken;
//          registers reached over an AXI4-Lite slave
`timescale 1ns/1ps
`include "dtok_params.svh"
module dtok_unit
  import dtok_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // operation from decode and execute
  input  wire logic        opValid,
  input  wire dtok_op_t    opCode,
  input  wire logic [6:0]  srcA,
  input  wire logic        srcAUse,
  input  wire logic [6:0]  srcB,
  input  wire logic        srcBUse,
  input  wire logic [81:0] fpSrcData,
  input  wire logic        fpSrcUse,
  input  wire logic [6:0]  dst,
  input  wire logic        dstIsFp,
  input  wire logic [63:0] memAddr,
  input  wire logic [3:0]  memSize,
  input  wire logic [63:0] grSrcData,
  input  wire logic [63:0] memRdData,
  input  wire logic        loadFault,
  input  wire logic [1:0]  faultClass,
  input  wire logic [63:0] chkTarget,
  input  wire logic        chkClr,
  // results to the pipeline
  output logic             opDone,
  output logic             consumeFault,
  output logic             loadFaultOut,
  output logic             recoverBranch,
  output logic [63:0]      recoverPc,
  output logic             testResult,
  output logic             grWrEn,
  output logic [6:0]       grWrReg,
  output logic             grWrToken,
  output logic [63:0]      grWrData,
  output logic             fpWrToken,
  output logic [81:0]      fpTokenValue,
  output logic             memWrEn,
  output logic [63:0]      memWrAddr,
  output logic [63:0]      memWrData,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [`DTOK_NUM_GR-1:0] grToken;
  logic [63:0]             collector;
  logic [63:0]             next_collector;
  logic [3:0]              deferMask;
  logic [6:0]              tokSel;
  logic [7:0]              faultCount;
  logic [6:0]              lastFaultReg;
  logic                    tokA;
  logic                    tokB;
  logic                    tokFp;
  logic                    anyTok;
  logic                    addrTok;
  logic                    deferOk;
  logic                    isSpec;
  logic                    isNonSpec;
  logic                    faultNow;
  logic [5:0]              collIdx;
  logic                    spillSet;
  logic                    tblHit;
  logic                    ctlDefer;
  logic                    wrDo;
  logic                    bwrSpill;

  // source token lookup, fp token by its reserved value
  assign tokA  = srcAUse && grToken[srcA];
  assign tokB  = srcBUse && grToken[srcB];
  assign tokFp = fpSrcUse && (fpSrcData == `DTOK_FP_TOKEN);
  assign anyTok  = tokA | tokB | tokFp;
  assign addrTok = tokA;
  assign deferOk = deferMask[faultClass];
  assign collIdx = memAddr[`DTOK_COLL_HI:`DTOK_COLL_LO];
  assign ctlDefer = loadFault && deferOk;

  // which operations tolerate tokens on their sources
  assign isSpec = (opCode == DTOK_OP_SPEC_ALU) ||
                  (opCode == DTOK_OP_CTRL_LOAD) ||
                  (opCode == DTOK_OP_SADV_LOAD);
  assign isNonSpec = (opCode == DTOK_OP_ALU) ||
                     (opCode == DTOK_OP_LOAD) ||
                     (opCode == DTOK_OP_ADV_LOAD) ||
                     (opCode == DTOK_OP_STORE);

  // checks and tests never fault on tokens; gr and fp spills and
  // fills only fault when the address register itself is a token
  always_comb begin
    faultNow = 1'b0;
    if (opValid) begin
      if (isNonSpec) begin
        faultNow = anyTok;
      end else if ((opCode == DTOK_OP_GR_SPILL) ||
                   (opCode == DTOK_OP_GR_FILL) ||
                   (opCode == DTOK_OP_FP_SPILL) ||
                   (opCode == DTOK_OP_FP_FILL)) begin
        faultNow = addrTok;
      end
    end
  end

  assign spillSet = opValid && !faultNow && (opCode == DTOK_OP_GR_SPILL);

  // address table: a deferred spec advanced load must leave no entry
  dtok_addr_table u_table (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .allocEn   (opValid && !faultNow &&
                ((opCode == DTOK_OP_ADV_LOAD) ||
                 ((opCode == DTOK_OP_SADV_LOAD) && !anyTok &&
                  !ctlDefer))),
    .allocReg  (dst),
    .allocAddr (memAddr),
    .allocFp   (dstIsFp),
    .allocSize (memSize),
    .killEn    (opValid && (opCode == DTOK_OP_SADV_LOAD) &&
                (anyTok || ctlDefer)),
    .killReg   (dst),
    .storeEn   (opValid && !faultNow &&
                ((opCode == DTOK_OP_STORE) ||
                 (opCode == DTOK_OP_GR_SPILL) ||
                 (opCode == DTOK_OP_FP_SPILL))),
    .storeAddr (memAddr),
    .chkReg    (srcA),
    .chkFp     (dstIsFp),
    .chkClr    (chkClr),
    .chkEn     (opValid && (opCode == DTOK_OP_ADV_CHK)),
    .chkHit    (tblHit)
  );

  // per-register token state; only the destination of the current
  // operation changes, so one load never touches another's token
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      grToken <= '0;
    end else if (opValid && !faultNow && !dstIsFp) begin
      case (opCode)
        DTOK_OP_SPEC_ALU:  grToken[dst] <= anyTok;
        DTOK_OP_CTRL_LOAD,
        DTOK_OP_SADV_LOAD: grToken[dst] <= anyTok || ctlDefer;
        DTOK_OP_ALU,
        DTOK_OP_LOAD,
        DTOK_OP_ADV_LOAD:  grToken[dst] <= 1'b0;
        DTOK_OP_GR_FILL:   grToken[dst] <= collector[collIdx];
        default:           grToken[dst] <= grToken[dst];
      endcase
    end
  end

  // pipeline results, all registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opDone        <= 1'b0;
      consumeFault  <= 1'b0;
      loadFaultOut  <= 1'b0;
      recoverBranch <= 1'b0;
      recoverPc     <= 64'h0000000000000000;
      testResult    <= 1'b0;
      grWrEn        <= 1'b0;
      grWrReg       <= 7'h00;
      grWrToken     <= 1'b0;
      grWrData      <= 64'h0000000000000000;
      fpWrToken     <= 1'b0;
      memWrEn       <= 1'b0;
      memWrAddr     <= 64'h0000000000000000;
      memWrData     <= 64'h0000000000000000;
    end else begin
      opDone        <= opValid;
      consumeFault  <= faultNow;
      loadFaultOut  <= opValid && loadFault && !deferOk &&
                       ((opCode == DTOK_OP_CTRL_LOAD) ||
                        (opCode == DTOK_OP_SADV_LOAD));
      recoverBranch <= 1'b0;
      testResult    <= 1'b0;
      grWrEn        <= 1'b0;
      fpWrToken     <= 1'b0;
      memWrEn       <= 1'b0;
      grWrReg       <= dst;
      recoverPc     <= chkTarget;
      if (opValid && !faultNow) begin
        case (opCode)
          DTOK_OP_SPEC_CHK: recoverBranch <= anyTok;
          DTOK_OP_ADV_CHK:  recoverBranch <= !tblHit;
          DTOK_OP_TOK_TEST,
          DTOK_OP_FP_CLASS: testResult <= anyTok;
          DTOK_OP_GR_SPILL: begin
            memWrEn   <= 1'b1;
            memWrAddr <= memAddr;
            memWrData <= grSrcData;
          end
          DTOK_OP_GR_FILL: begin
            grWrEn    <= 1'b1;
            grWrToken <= collector[collIdx];
            grWrData  <= memRdData;
          end
          DTOK_OP_SPEC_ALU,
          DTOK_OP_CTRL_LOAD,
          DTOK_OP_SADV_LOAD: begin
            // fp destinations get the reserved value, not a bit
            fpWrToken <= dstIsFp && (anyTok ||
                         (ctlDefer && opCode != DTOK_OP_SPEC_ALU));
            grWrEn    <= !dstIsFp;
            grWrToken <= anyTok || (ctlDefer &&
                         opCode != DTOK_OP_SPEC_ALU);
            grWrData  <= memRdData;
          end
          default: ;
        endcase
      end
    end
  end

  // fixed token pattern offered to the fp register file
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fpTokenValue <= 82'h000000000000000000000;
    end else begin
      fpTokenValue <= `DTOK_FP_TOKEN;
    end
  end

  // fault statistics so software can see consumption events
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultCount   <= 8'h00;
      lastFaultReg <= 7'h00;
    end else if (faultNow) begin
      faultCount   <= faultCount + 8'h01;
      lastFaultReg <= tokA ? srcA : srcB;
    end
  end

  // AXI4-Lite write side: address and data latched in either order
  dtok_bus_t  wrState;
  logic       awHeld;
  logic       wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  assign wrDo = (wrState == DTOK_BUS_IDLE) && awHeld && wHeld;
  assign bwrSpill = spillSet;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrState       <= DTOK_BUS_IDLE;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DTOK_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (wrState)
        DTOK_BUS_IDLE: begin
          if (wrDo) begin
            wrState      <= DTOK_BUS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ((awAddr == `DTOK_OFF_CTRL) ||
                             (awAddr == `DTOK_OFF_COLL_LO) ||
                             (awAddr == `DTOK_OFF_COLL_HI) ||
                             (awAddr == `DTOK_OFF_TOKSEL)) ?
                            `DTOK_RESP_OKAY : `DTOK_RESP_SLVERR;
          end
        end
        DTOK_BUS_RESP: begin
          if (s_axi_bready) begin
            wrState       <= DTOK_BUS_IDLE;
            s_axi_bvalid  <= 1'b0;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
        default: wrState <= DTOK_BUS_IDLE;
      endcase
    end
  end

  // control registers written by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      deferMask <= `DTOK_CTRL_RESET;
      tokSel    <= 7'h00;
    end else if (wrDo) begin
      if (awAddr == `DTOK_OFF_CTRL && wStrb[0]) begin
        deferMask <= wData[3:0];
      end
      if (awAddr == `DTOK_OFF_TOKSEL && wStrb[0]) begin
        tokSel <= wData[6:0];
      end
    end
  end

  // collector: software restores it, a spill in the same cycle wins
  // for its own bit so no spilled token is lost
  always_comb begin
    next_collector = collector;
    if (wrDo && awAddr == `DTOK_OFF_COLL_LO) begin
      next_collector[31:0] = mergeStrb(collector[31:0], wData, wStrb);
    end
    if (wrDo && awAddr == `DTOK_OFF_COLL_HI) begin
      next_collector[63:32] = mergeStrb(collector[63:32], wData, wStrb);
    end
    if (bwrSpill) begin
      next_collector[collIdx] = grToken[srcB];
    end
  end

  // registered collector
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      collector <= 64'h0000000000000000;
    end else begin
      collector <= next_collector;
    end
  end

  // AXI4-Lite read side
  dtok_bus_t rdState;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdState       <= DTOK_BUS_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DTOK_RESP_OKAY;
    end else begin
      case (rdState)
        DTOK_BUS_IDLE: begin
          if (s_axi_arvalid) begin
            rdState       <= DTOK_BUS_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `DTOK_RESP_OKAY;
            case (s_axi_araddr)
              `DTOK_OFF_CTRL:    s_axi_rdata <= {28'h0000000, deferMask};
              `DTOK_OFF_COLL_LO: s_axi_rdata <= collector[31:0];
              `DTOK_OFF_COLL_HI: s_axi_rdata <= collector[63:32];
              `DTOK_OFF_STATUS:  s_axi_rdata <= {17'h00000, lastFaultReg,
                                                 faultCount};
              `DTOK_OFF_TOKSEL:  s_axi_rdata <= {25'h0000000, tokSel};
              `DTOK_OFF_TOKVAL:  s_axi_rdata <= {31'h00000000,
                                                 grToken[tokSel]};
              default: begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `DTOK_RESP_SLVERR;
              end
            endcase
          end
        end
        DTOK_BUS_RESP: begin
          if (s_axi_rready) begin
            rdState       <= DTOK_BUS_IDLE;
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: rdState <= DTOK_BUS_IDLE;
      endcase
    end
  end

endmodule

// ==== bench/dtok_unit_monitor.sv ====
// Purpose: port checks for dtok_unit
// Assumes: answers land one edge after an operation is taken
// Notes:   bound into every dtok_unit instance
`timescale 1ns/1ps
`include "dtok_params.svh"
module dtok_unit_monitor
  import dtok_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // operation
  input wire logic        opValid,
  input wire dtok_op_t    opCode,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] grSrcData,
  input wire logic [63:0] memRdData,
  input wire logic        loadFault,
  // results
  input wire logic        opDone,
  input wire logic        consumeFault,
  input wire logic        loadFaultOut,
  input wire logic        grWrEn,
  input wire logic [63:0] grWrData,
  input wire logic [81:0] fpTokenValue,
  input wire logic        memWrEn,
  input wire logic [63:0] memWrAddr,
  input wire logic [63:0] memWrData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // every op answers next edge, so none can stall another
  a_done_follows: assert property (opValid |=> opDone)
    else $error("operation not answered");
  a_spill_data: assert property (opValid && opCode == DTOK_OP_GR_SPILL
    |=> memWrEn && memWrData == $past(grSrcData)) else $error("spill data");
  a_spill_addr: assert property (opValid && opCode == DTOK_OP_GR_SPILL
    |=> memWrAddr == $past(memAddr)) else $error("spill address");
  a_fill_data: assert property (opValid && opCode == DTOK_OP_GR_FILL
    |=> grWrEn && grWrData == $past(memRdData)) else $error("fill data");
  // tests and checks read tokens without faulting
  a_test_quiet: assert property (opValid && opCode inside
    {DTOK_OP_SPEC_CHK, DTOK_OP_TOK_TEST, DTOK_OP_FP_CLASS}
    |=> !consumeFault) else $error("test raised a fault");
  a_fp_token: assert property (!$past(sys_rst)
    |-> fpTokenValue == `DTOK_FP_TOKEN) else $error("fp token pattern");
  a_clean_load: assert property (opValid && opCode == DTOK_OP_CTRL_LOAD
    && !loadFault |=> !loadFaultOut) else $error("fault without cause");
  a_idle_quiet: assert property (!opValid
    |=> !memWrEn && !consumeFault && !opDone) else $error("idle pulse");
endmodule
bind dtok_unit dtok_unit_monitor mon (
  .clk, .sys_rst, .opValid, .opCode, .memAddr, .grSrcData, .memRdData,
  .loadFault, .opDone, .consumeFault, .loadFaultOut, .grWrEn, .grWrData,
  .fpTokenValue, .memWrEn, .memWrAddr, .memWrData
);

// ==== bench/dtok_mem_model.sv ====
// Purpose: doubleword memory behind the unit's load and spill ports
// Assumes: one spill write per edge
// Notes:   aliases every 512 bytes; unwritten words read as zero
`timescale 1ns/1ps
module dtok_mem_model (
  // clock
  input  wire logic        clk,
  // spill writes
  input  wire logic        memWrEn,
  input  wire logic [63:0] memWrAddr,
  input  wire logic [63:0] memWrData,
  // loads
  input  wire logic [63:0] memAddr,
  output logic      [63:0] memRdData
);
  logic [63:0] mem [64] = '{default: '0};
  // whole eight-byte words only
  always @(posedge clk) begin
    if (memWrEn) begin
      mem[memWrAddr[8:3]] <= memWrData;
    end
  end
  assign memRdData = mem[memAddr[8:3]];
endmodule

// ==== bench/test_deferred_exception_token_tracking.sv ====
// Purpose: directed bench for dtok_unit
// Assumes: ops answer one edge later, bus waits on handshakes
// Notes:   chkTarget and spill data are derived from memAddr;
//          dst bit 6 marks an fp destination
`timescale 1ns/1ps
`include "dtok_params.svh"
module test_deferred_exception_token_tracking
  import dtok_pkg::*;
;
  // stimulus
  logic        clk = '0, sys_rst = '1, opValid = '0, loadFault = '0;
  dtok_op_t    opCode = DTOK_OP_NONE;
  logic [6:0]  srcA = '0, srcB = '0, dst = '0;
  logic [63:0] memAddr = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rdv;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  // answers
  logic        consumeFault, loadFaultOut, recoverBranch, testResult;
  logic        grWrToken, fpWrToken, memWrEn, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic [63:0] memRdData, recoverPc, grWrData, memWrAddr, memWrData;
  int          mismatches = 0, checksDone = 0;
  always #20 clk = ~clk;
  dtok_unit DUT (
    .clk, .sys_rst, .opValid, .opCode, .srcA, .srcAUse(opValid), .srcB,
    .srcBUse(srcB != 7'h0), .fpSrcData(`DTOK_FP_TOKEN ^ {18'h0, memAddr}),
    .fpSrcUse(opCode == DTOK_OP_FP_CLASS || opCode == DTOK_OP_FP_SPILL),
    .dst, .dstIsFp(dst[6]), .memAddr, .memSize(4'h8), .grSrcData(~memAddr),
    .memRdData, .loadFault, .faultClass(2'h0), .chkTarget(memAddr),
    .chkClr(1'h0), .opDone(), .consumeFault, .loadFaultOut, .recoverBranch,
    .recoverPc, .testResult, .grWrEn(), .grWrReg(), .grWrToken, .grWrData,
    .fpWrToken, .fpTokenValue(), .memWrEn, .memWrAddr, .memWrData,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dtok_mem_model mem (
    .clk, .memWrEn, .memWrAddr, .memWrData, .memAddr, .memRdData);
  task automatic ck(input logic [63:0] got, input logic [63:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // one op, sampled once its answer has landed
  task automatic op(input dtok_op_t c, input logic [6:0] a, b, d,
                    input logic [63:0] adr, input logic f);
    @(posedge clk);
    opValid <= 1'h1;
    opCode <= c;
    srcA <= a;
    srcB <= b;
    dst <= d;
    memAddr <= adr;
    loadFault <= f;
    @(posedge clk);
    opValid <= 1'h0;
    #1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      #1;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic achk(input logic [6:0] r, input logic e);
    op(DTOK_OP_ADV_CHK, r, 7'h0, 7'h0, 64'h2000, 1'h0);
    ck(recoverBranch, e);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // the run needs about a hundred cycles
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    axr(`DTOK_OFF_CTRL);
    ck(rdv, 32'hF);
    axr(8'h20);
    ck(rsp, `DTOK_RESP_SLVERR);
    op(DTOK_OP_CTRL_LOAD, 7'h0, 7'h0, 7'h5, 64'h40, 1'h1);
    ck({grWrToken, loadFaultOut}, 2'h2);
    axw(`DTOK_OFF_TOKSEL, 32'h5);
    axr(`DTOK_OFF_TOKVAL);
    ck(rdv[0], 1'h1);
    axw(`DTOK_OFF_CTRL, 32'h0);
    op(DTOK_OP_CTRL_LOAD, 7'h0, 7'h0, 7'h7, 64'h48, 1'h1);
    ck(loadFaultOut, 1'h1);
    axw(`DTOK_OFF_CTRL, 32'hF);
    op(DTOK_OP_CTRL_LOAD, 7'h0, 7'h0, 7'hD, 64'h50, 1'h0);
    ck(grWrToken, 1'h0);
    op(DTOK_OP_CTRL_LOAD, 7'h0, 7'h0, 7'h45, 64'h58, 1'h1);
    ck(fpWrToken, 1'h1);
    $display("test deferral done");
    op(DTOK_OP_SPEC_ALU, 7'h5, 7'hD, 7'h6, 64'h0, 1'h0);
    ck(grWrToken, 1'h1);
    op(DTOK_OP_ALU, 7'h0, 7'h6, 7'h8, 64'h8, 1'h0);
    ck(consumeFault, 1'h1);
    op(DTOK_OP_TOK_TEST, 7'h6, 7'h0, 7'h8, 64'h8, 1'h0);
    ck({testResult, consumeFault}, 2'h2);
    op(DTOK_OP_FP_CLASS, 7'h0, 7'h0, 7'h8, 64'h0, 1'h0);
    ck(testResult, 1'h1);
    op(DTOK_OP_FP_CLASS, 7'h0, 7'h0, 7'h8, 64'h8, 1'h0);
    ck(testResult, 1'h0);
    op(DTOK_OP_SPEC_CHK, 7'h6, 7'h0, 7'h0, 64'h1230, 1'h0);
    ck(recoverPc, 64'h1230);
    ck(recoverBranch, 1'h1);
    op(DTOK_OP_SPEC_CHK, 7'h7, 7'h0, 7'h0, 64'h1240, 1'h0);
    ck(recoverBranch, 1'h0);
    op(DTOK_OP_GR_SPILL, 7'h0, 7'h6, 7'h0, 64'h28, 1'h0);
    ck(memWrData, ~64'h28);
    axr(`DTOK_OFF_COLL_LO);
    ck(rdv, 32'h20);
    axw(`DTOK_OFF_COLL_LO, 32'h0);
    op(DTOK_OP_GR_FILL, 7'h0, 7'h0, 7'h6, 64'h28, 1'h0);
    ck(grWrToken, 1'h0);
    axw(`DTOK_OFF_COLL_LO, 32'h20);
    op(DTOK_OP_GR_FILL, 7'h0, 7'h0, 7'h6, 64'h28, 1'h0);
    ck({grWrToken, grWrData[62:0]}, {1'h1, ~63'h28});
    op(DTOK_OP_FP_SPILL, 7'h0, 7'h0, 7'h0, 64'h0, 1'h0);
    ck(consumeFault, 1'h0);
    $display("test tokens done");
    op(DTOK_OP_ADV_LOAD, 7'h0, 7'h0, 7'h9, 64'h100, 1'h0);
    achk(7'h9, 1'h0);
    op(DTOK_OP_STORE, 7'h0, 7'h0, 7'h0, 64'h104, 1'h0);
    achk(7'h9, 1'h1);
    op(DTOK_OP_SADV_LOAD, 7'h0, 7'h0, 7'hA, 64'h140, 1'h1);
    ck(grWrToken, 1'h1);
    achk(7'hA, 1'h1);
    op(DTOK_OP_ADV_LOAD, 7'h0, 7'h0, 7'hB, 64'h180, 1'h0);
    op(DTOK_OP_ADV_LOAD, 7'h0, 7'h0, 7'h3, 64'h1C0, 1'h0);
    achk(7'hB, 1'h1);
    achk(7'h3, 1'h0);
    $display("test table done");
    end_sim;
  end
endmodule
